/* logic/fupc_pkg.sv */
// ==========================================================================
// Flash user program control constants
package fupc_pkg;
  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_OP_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_UNLOCK_KEY  = 8'h04;
  localparam logic [7:0] OFS_SECTOR_HIGH = 8'h08;
  localparam logic [7:0] OFS_SECTOR_LOW  = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h14;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_UNLOCK_KEY  = 8'h00;
  localparam logic [7:0] RST_SECTOR      = 8'h00;
  localparam logic [3:0] RST_MODE        = 4'h0;
  // ==========================================================================
  // Key and control field layout
  localparam logic [7:0] UNLOCK_KEY      = 8'ha5;
  localparam int         CTL_MODE_LSB    = 4;
  localparam int         CTL_STATUS_BIT  = 3;
  localparam int         CTL_START_BIT   = 0;
  localparam logic [3:0] MODE_ERASE      = 4'ha;
  localparam logic [3:0] MODE_PROGRAM    = 4'h5;
  localparam logic [3:0] MODE_HARD_LOCK  = 4'h6;
  localparam int         SECL_BASE_BIT   = 7;
  // ==========================================================================
  // Event bits of status and mask registers
  localparam int         EV_ERASE_DONE   = 0;
  localparam int         EV_ERASE_FAIL   = 1;
  localparam int         EV_LOCK_DONE    = 2;
  localparam int         EV_WRITE_REFUSE = 3;
  localparam int         EV_COUNT        = 4;
  // ==========================================================================
  // Array geometry
  localparam int         FLASH_BYTES     = 65536;
  localparam int         SECTOR_BYTES    = 128;
  localparam int         SECTOR_COUNT    = 512;
  localparam logic [7:0] ERASED_BYTE     = 8'hff;
  // ==========================================================================
  // Timing
  localparam int         CLK_PERIOD_NS   = 10;
  localparam int         ERASE_TIME_MS   = 10;
  localparam int         ERASE_CYCLES    = (ERASE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS;
  localparam int         LOCK_TIME_US    = 10;
  localparam int         LOCK_CYCLES     = (LOCK_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS;
  localparam int         CNT_W           = 20;
endpackage

/* logic/fupc_top.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - Control register writes act only while user program mode is unlocked.
// - Control bit 0 launches the selected erase or hard lock.
// - Byte reads and programming go through the load port, without start bit.
// - Sector erase status bit is readable, never writable by software.
// - Interrupt request during erase aborts it and marks it failed.
// - Erase status reads zero on success, one on failure.
// - Unlock key register resets to zero, mode disabled.
// - Only the exact key value enables erase, programming and hard lock.
// - Erase, program, read and hard lock offered; no read protection here.
// - Array is 512 sectors of 128 bytes, chosen by high and low bytes.
// - Sectors start at 00 or 80; low bits 6 to 0 are ignored.
// - 64K-byte flash, erased by sector and programmed by byte.
// - Sector erase lasts at least 10 ms after the start bit.
// - Value a1 starts erase; value 50 selects byte programming.
// - Sector erase exists only in user program mode.
module fupc_top #(
  parameter int ERASE_CYCLES = fupc_pkg::ERASE_CYCLES,
  parameter int LOCK_CYCLES  = fupc_pkg::LOCK_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Program memory load port
  input  wire logic        pm_req_i,
  input  wire logic        pm_we_i,
  input  wire logic [15:0] pm_addr_i,
  input  wire logic [7:0]  pm_wdata_i,
  output logic      [7:0]  pm_rdata_o,
  output logic             pm_ack_o,
  // Interrupts and busy flag
  input  wire logic        irq_req_i,
  output logic             irq_o,
  output logic             busy_o
);
  // ==========================================================================
  // State
  typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_LOCK} fupc_op_t;

  typedef struct packed {
    logic [7:0]                    key;
    logic [3:0]                    mode;
    logic                          erase_fail;
    logic                          locked;
    logic [7:0]                    sech;
    logic [7:0]                    secl;
    fupc_op_t                      op;
    logic [fupc_pkg::CNT_W-1:0]    cnt;
    logic [fupc_pkg::EV_COUNT-1:0] sts;
    logic [fupc_pkg::EV_COUNT-1:0] msk;
    logic                          wb_ack;
    logic [31:0]                   wb_dat;
    logic                          pm_ack;
  } fupc_state_t;

  fupc_state_t r;
  fupc_state_t next_r;

  logic [7:0] mem [fupc_pkg::FLASH_BYTES];
  logic [7:0] pm_rdata;

  logic       wb_req;
  logic       wb_wr;
  logic       unlocked;
  logic       ctl_wr;
  logic       pm_take;
  logic       pm_prog_ok;
  logic       erase_end;
  logic [8:0] sector;
  logic [fupc_pkg::EV_COUNT-1:0] ev;

  // ==========================================================================
  // Decode
  assign wb_req     = cyc_i && stb_i && !r.wb_ack;
  assign wb_wr      = wb_req && we_i && sel_i[0];
  assign unlocked   = (r.key == fupc_pkg::UNLOCK_KEY);
  assign ctl_wr     = wb_wr && (adr_i == fupc_pkg::OFS_OP_CONTROL) && unlocked;
  assign pm_take    = pm_req_i && !r.pm_ack;
  assign pm_prog_ok = unlocked && !r.locked && (r.op == OP_IDLE)
                      && (r.mode == fupc_pkg::MODE_PROGRAM);
  assign sector     = {r.sech, r.secl[fupc_pkg::SECL_BASE_BIT]};
  assign erase_end  = (r.op == OP_ERASE) && (r.cnt == '0) && !irq_req_i;

  // ==========================================================================
  // Next state
  always_comb begin
    next_r        = r;
    ev            = '0;
    next_r.wb_ack = wb_req;
    next_r.pm_ack = pm_take;
    // Register writes
    if (wb_wr) begin
      unique case (adr_i)
        fupc_pkg::OFS_UNLOCK_KEY:  next_r.key  = dat_i[7:0];
        fupc_pkg::OFS_SECTOR_HIGH: next_r.sech = dat_i[7:0];
        fupc_pkg::OFS_SECTOR_LOW:  next_r.secl = dat_i[7:0];
        fupc_pkg::OFS_IRQ_MASK:    next_r.msk  = dat_i[fupc_pkg::EV_COUNT-1:0];
        fupc_pkg::OFS_IRQ_STATUS:  next_r.sts  = r.sts & ~dat_i[fupc_pkg::EV_COUNT-1:0];
        default: ;
      endcase
    end
    // Control register: mode select and start, status bit untouched
    if (ctl_wr && (r.op == OP_IDLE)) begin
      next_r.mode = dat_i[fupc_pkg::CTL_MODE_LSB +: 4];
      if (dat_i[fupc_pkg::CTL_START_BIT] && !r.locked) begin
        if (dat_i[fupc_pkg::CTL_MODE_LSB +: 4] == fupc_pkg::MODE_ERASE) begin
          next_r.op         = OP_ERASE;
          next_r.cnt        = fupc_pkg::CNT_W'(ERASE_CYCLES - 1);
          next_r.erase_fail = 1'b0;
        end else if (dat_i[fupc_pkg::CTL_MODE_LSB +: 4] == fupc_pkg::MODE_HARD_LOCK) begin
          next_r.op  = OP_LOCK;
          next_r.cnt = fupc_pkg::CNT_W'(LOCK_CYCLES - 1);
        end
      end
    end
    // Running operations
    unique case (r.op)
      OP_ERASE: begin
        if (irq_req_i) begin
          next_r.op         = OP_IDLE;
          next_r.erase_fail = 1'b1;
          ev[fupc_pkg::EV_ERASE_FAIL] = 1'b1;
        end else if (r.cnt == '0) begin
          next_r.op         = OP_IDLE;
          next_r.erase_fail = 1'b0;
          ev[fupc_pkg::EV_ERASE_DONE] = 1'b1;
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
      OP_LOCK: begin
        if (r.cnt == '0) begin
          next_r.op     = OP_IDLE;
          next_r.locked = 1'b1;
          ev[fupc_pkg::EV_LOCK_DONE] = 1'b1;
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
      OP_IDLE: ;
    endcase
    if (pm_take && pm_we_i && !pm_prog_ok) begin
      ev[fupc_pkg::EV_WRITE_REFUSE] = 1'b1;
    end
    // Set wins over write-one clear
    next_r.sts = next_r.sts | ev;
    // Read data
    next_r.wb_dat = '0;
    if (wb_req && !we_i) begin
      unique case (adr_i)
        fupc_pkg::OFS_OP_CONTROL:
          next_r.wb_dat = {24'h000000, r.mode, r.erase_fail, 2'b00,
                           (r.op != OP_IDLE)};
        fupc_pkg::OFS_UNLOCK_KEY:  next_r.wb_dat = {24'h000000, r.key};
        fupc_pkg::OFS_SECTOR_HIGH: next_r.wb_dat = {24'h000000, r.sech};
        fupc_pkg::OFS_SECTOR_LOW:  next_r.wb_dat = {24'h000000, r.secl};
        fupc_pkg::OFS_IRQ_STATUS:  next_r.wb_dat = {28'h0000000, r.sts};
        fupc_pkg::OFS_IRQ_MASK:    next_r.wb_dat = {28'h0000000, r.msk};
        default:                   next_r.wb_dat = '0;
      endcase
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r.key        <= fupc_pkg::RST_UNLOCK_KEY;
      r.mode       <= fupc_pkg::RST_MODE;
      r.erase_fail <= 1'b0;
      r.locked     <= 1'b0;
      r.sech       <= fupc_pkg::RST_SECTOR;
      r.secl       <= fupc_pkg::RST_SECTOR;
      r.op         <= OP_IDLE;
      r.cnt        <= '0;
      r.sts        <= '0;
      r.msk        <= '0;
      r.wb_ack     <= 1'b0;
      r.wb_dat     <= '0;
      r.pm_ack     <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // Flash array: load port reads and programs, sector erase at the end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pm_rdata <= '0;
    end else begin
      if (pm_take) begin
        pm_rdata <= mem[pm_addr_i];
        if (pm_we_i && pm_prog_ok) begin
          mem[pm_addr_i] <= mem[pm_addr_i] & pm_wdata_i;
        end
      end
      if (erase_end) begin
        for (int i = 0; i < fupc_pkg::SECTOR_BYTES; i++) begin
          mem[{sector, 7'(i)}] <= fupc_pkg::ERASED_BYTE;
        end
      end
    end
  end

  // ==========================================================================
  // Outputs
  assign dat_o      = r.wb_dat;
  assign ack_o      = r.wb_ack;
  assign pm_rdata_o = pm_rdata;
  assign pm_ack_o   = r.pm_ack;
  assign irq_o      = |(r.sts & r.msk);
  assign busy_o     = (r.op != OP_IDLE);

  // ==========================================================================
  // Assertions
  sequence s_ctl_write(logic [7:0] v);
    ctl_wr && (dat_i[7:0] == v) && (r.op == OP_IDLE) && !r.locked;
  endsequence

  sequence s_erase_running;
    (r.op == OP_ERASE) && !irq_req_i;
  endsequence

  AST_KEY_RESET: assert property (@(posedge clk_i)
    rst_i |=> (r.key == 8'h00) && !busy_o)
    else $error("Unlock key not cleared by reset");

  AST_NO_KEY_NO_START: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_wr && adr_i == fupc_pkg::OFS_OP_CONTROL && dat_i[0] && !unlocked
     && r.op == OP_IDLE) |=> (r.op == OP_IDLE))
    else $error("Operation started without the key");

  AST_ERASE_START: assert property (@(posedge clk_i) disable iff (rst_i)
    s_ctl_write(8'ha1) |=> (r.op == OP_ERASE) && busy_o && !r.erase_fail)
    else $error("Erase did not start on a1 write");

  AST_ERASE_MIN_TIME: assert property (@(posedge clk_i) disable iff (rst_i)
    s_ctl_write(8'ha1) ##1 s_erase_running [*8] |=> busy_o)
    else $error("Erase ended too early");

  AST_ABORT: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.op == OP_ERASE && irq_req_i) |=> !busy_o && r.erase_fail
      && r.sts[fupc_pkg::EV_ERASE_FAIL])
    else $error("Interrupt did not abort the erase");

  AST_STATUS_RO: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_wr && adr_i == fupc_pkg::OFS_OP_CONTROL && r.op == OP_IDLE)
    |=> $stable(r.erase_fail) || (r.op == OP_ERASE))
    else $error("Erase status changed by software write");

  AST_ERASE_OK: assert property (@(posedge clk_i) disable iff (rst_i)
    erase_end |=> !r.erase_fail && r.sts[fupc_pkg::EV_ERASE_DONE])
    else $error("Finished erase not reported as success");

  AST_PM_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
    pm_take |=> pm_ack_o ##1 !pm_ack_o)
    else $error("Load access not acknowledged in one cycle");

  AST_WRITE_REFUSED: assert property (@(posedge clk_i) disable iff (rst_i)
    (pm_take && pm_we_i && !unlocked) |=> r.sts[fupc_pkg::EV_WRITE_REFUSE])
    else $error("Write without key not flagged");

  AST_PROG_MODE: assert property (@(posedge clk_i) disable iff (rst_i)
    s_ctl_write(8'h50) |=> (r.mode == fupc_pkg::MODE_PROGRAM) && !busy_o)
    else $error("Value 50 did not select programming");

  AST_NO_MODE_LOCKED: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_wr && adr_i == fupc_pkg::OFS_OP_CONTROL && !unlocked) |=> $stable(r.mode))
    else $error("Control register changed outside user program mode");

  AST_LOCK_BLOCKS: assert property (@(posedge clk_i) disable iff (rst_i)
    r.locked && ctl_wr |=> !busy_o)
    else $error("Operation started after hard lock");

  // ==========================================================================
  // Timing, lock and load port checks
  sequence s_lock_write;
    ctl_wr && (dat_i[7:4] == fupc_pkg::MODE_HARD_LOCK) && dat_i[fupc_pkg::CTL_START_BIT]
    && (r.op == OP_IDLE) && !r.locked;
  endsequence

  sequence s_lock_running;
    (r.op == OP_LOCK) && (r.cnt != '0);
  endsequence

  AST_ERASE_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    s_ctl_write(8'ha1) |=> (r.cnt == fupc_pkg::CNT_W'(ERASE_CYCLES - 1)))
    else $error("Erase timer not loaded with the full time");

  AST_ERASE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    s_erase_running ##0 (r.cnt != '0) |=> busy_o && (r.cnt == $past(r.cnt) - 1'b1))
    else $error("Erase ended before its time");

  AST_ERASE_FILL: assert property (@(posedge clk_i) disable iff (rst_i)
    erase_end |=> (mem[{$past(sector), 7'h00}] == fupc_pkg::ERASED_BYTE)
      && (mem[{$past(sector), 7'h7f}] == fupc_pkg::ERASED_BYTE))
    else $error("Erased sector not filled");

  AST_LOCK_START: assert property (@(posedge clk_i) disable iff (rst_i)
    s_lock_write |=> (r.op == OP_LOCK) && busy_o)
    else $error("Hard lock did not start");

  AST_LOCK_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    s_lock_running |=> busy_o && !r.locked)
    else $error("Hard lock took effect early");

  AST_LOCK_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.op == OP_LOCK) && (r.cnt == '0) |=> r.locked && !busy_o
      && r.sts[fupc_pkg::EV_LOCK_DONE])
    else $error("Hard lock end not recorded");

  AST_REFUSE_ANY: assert property (@(posedge clk_i) disable iff (rst_i)
    (pm_take && pm_we_i && !pm_prog_ok) |=> r.sts[fupc_pkg::EV_WRITE_REFUSE])
    else $error("Refused load write not flagged");

  AST_BUSY_IGNORES: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctl_wr && r.op != OP_IDLE) |=> $stable(r.mode))
    else $error("Control write acted during an operation");

  AST_RESET_OUTPUTS: assert property (@(posedge clk_i)
    rst_i |=> !ack_o && !pm_ack_o && !irq_o && (dat_o == '0))
    else $error("Outputs not quiet after reset");

  AST_PM_READ: assert property (@(posedge clk_i) disable iff (rst_i)
    (pm_take && !pm_we_i) |=> pm_ack_o && (pm_rdata_o == $past(mem[pm_addr_i])))
    else $error("Load read did not return the stored byte");

  AST_KEY_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_wr && adr_i == fupc_pkg::OFS_UNLOCK_KEY && dat_i[7:0] != fupc_pkg::UNLOCK_KEY)
    |=> !unlocked)
    else $error("Wrong key left the flash unlocked");

endmodule

/* testbench/tb.sv */
`timescale 1ns/100ps
module tb;
  // ==========================================================================
  // Bench constants
  localparam int         EC   = 20;
  localparam int         LC   = 10;
  localparam logic [7:0] ACTL = fupc_pkg::OFS_OP_CONTROL;
  localparam logic [7:0] AKEY = fupc_pkg::OFS_UNLOCK_KEY;
  localparam logic [7:0] AHI  = fupc_pkg::OFS_SECTOR_HIGH;
  localparam logic [7:0] ALO  = fupc_pkg::OFS_SECTOR_LOW;
  localparam logic [7:0] ASTA = fupc_pkg::OFS_IRQ_STATUS;
  localparam logic [7:0] AMSK = fupc_pkg::OFS_IRQ_MASK;
  // ==========================================================================
  // Signals
  logic        clk_i      = 1'b0;
  logic        rst_i      = 1'b1;
  logic        cyc_i      = 1'b0;
  logic        stb_i      = 1'b0;
  logic        we_i       = 1'b0;
  logic [7:0]  adr_i      = 8'h00;
  logic [3:0]  sel_i      = 4'h0;
  logic [31:0] dat_i      = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        pm_req_i   = 1'b0;
  logic        pm_we_i    = 1'b0;
  logic [15:0] pm_addr_i  = 16'h0;
  logic [7:0]  pm_wdata_i = 8'h00;
  logic [7:0]  pm_rdata_o;
  logic        pm_ack_o;
  logic        irq_req_i  = 1'b0;
  logic        irq_o;
  logic        busy_o;
  int          fails      = 0;
  int          checks     = 0;
  int          bcnt       = 0;
  integer      seed;
  logic [31:0] q;
  logic [31:0] v;
  logic [7:0]  pv;
  always #5 clk_i = ~clk_i;
  always @(negedge clk_i) if (busy_o === 1'b1) bcnt++;
  fupc_top #(.ERASE_CYCLES(EC), .LOCK_CYCLES(LC)) u_fupc_top (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .pm_req_i(pm_req_i), .pm_we_i(pm_we_i), .pm_addr_i(pm_addr_i),
    .pm_wdata_i(pm_wdata_i), .pm_rdata_o(pm_rdata_o), .pm_ack_o(pm_ack_o),
    .irq_req_i(irq_req_i), .irq_o(irq_o), .busy_o(busy_o));
  // ==========================================================================
  // Checking and closing
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================================
  // Wishbone classic cycle and load port access
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hf;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    if (n >= 50) begin chk("wb timeout", 1, 0); close_out(); end
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic pm(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    pm_req_i <= 1'b1; pm_we_i <= w; pm_addr_i <= a; pm_wdata_i <= d;
    do begin @(posedge clk_i); n++; end while (pm_ack_o !== 1'b1 && n < 50);
    q = {24'h0, pm_rdata_o};
    pm_req_i <= 1'b0;
    if (n >= 50) begin chk("pm timeout", 1, 0); close_out(); end
    @(posedge clk_i);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy_o === 1'b1 && n < 5000) begin @(posedge clk_i); n++; end
    if (n >= 5000) begin chk("busy timeout", 1, 0); close_out(); end
  endtask
  task automatic start_erase(input logic [7:0] hi, input logic [7:0] lo);
    wr(AKEY, 32'ha5); wr(AHI, {24'h0, hi}); wr(ALO, {24'h0, lo});
    bcnt = 0;
    wr(ACTL, 32'ha1);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    seed = 32'h51914757;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(AKEY); chk("key reset", q, 32'h0);
    rd(ACTL); chk("ctl reset", q, 32'h0);
    rd(8'h40); chk("unmapped", q, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      if (v[7:0] == fupc_pkg::UNLOCK_KEY) v[0] = ~v[0];
      wr(AKEY, {24'h0, v[7:0]}); wr(ACTL, 32'ha1);
      rd(ACTL); chk("ctl no key", q, 32'h0);
    end
    chk("busy no key", bcnt, 0);
    $display("test key done");
    wr(AMSK, 32'hf);
    v = $random(seed);
    start_erase(8'h13, {1'b0, v[6:0]}); wait_idle();
    chk("erase length", bcnt, EC);
    rd(ASTA); chk("erase done ev", q, 32'h1);
    chk("irq on", {31'h0, irq_o}, 1);
    rd(ACTL); chk("erase ok", q, 32'ha0);
    pm(1'b0, 16'h1300, 8'h00); chk("erased lo", q, 32'hff);
    pm(1'b0, 16'h137f, 8'h00); chk("erased hi", q, 32'hff);
    wr(ASTA, 32'hf); chk("irq clear", {31'h0, irq_o}, 0);
    wr(ACTL, 32'h50); pv = v[15:8];
    pm(1'b1, 16'h1300, pv); pm(1'b0, 16'h1300, 8'h00);
    chk("prog byte", q, {24'h0, pv});
    pm(1'b1, 16'h1300, v[23:16]); pv = pv & v[23:16];
    pm(1'b0, 16'h1300, 8'h00); chk("prog and", q, {24'h0, pv});
    wr(ACTL, 32'h58); rd(ACTL); chk("status ro", q, 32'h50);
    start_erase(8'h12, 8'h80 | v[31:24]);
    wr(ACTL, 32'h50); rd(ACTL); chk("busy ignores", q, 32'ha1);
    wait_idle();
    pm(1'b0, 16'h12ff, 8'h00); chk("other sector", q, 32'hff);
    pm(1'b0, 16'h1300, 8'h00); chk("kept sector", q, {24'h0, pv});
    wr(ASTA, 32'hf);
    $display("test erase done");
    start_erase(8'h13, 8'h00);
    repeat (3) @(posedge clk_i);
    irq_req_i <= 1'b1;
    @(posedge clk_i);
    irq_req_i <= 1'b0;
    wait_idle();
    rd(ACTL); chk("abort fail", q, 32'ha8);
    rd(ASTA); chk("fail ev", q, 32'h2);
    chk("abort short", {31'h0, bcnt < EC}, 1);
    pm(1'b0, 16'h1300, 8'h00); chk("abort no erase", q, {24'h0, pv});
    wr(ASTA, 32'hf); wr(AMSK, 32'h0);
    start_erase(8'h13, 8'h00); wait_idle();
    rd(ACTL); chk("retry ok", q, 32'ha0);
    rd(ASTA); chk("masked ev", q, 32'h1);
    chk("masked irq", {31'h0, irq_o}, 0);
    wr(ASTA, 32'hf); wr(AMSK, 32'hf);
    $display("test abort done");
    wr(ACTL, 32'h50); wr(AKEY, 32'h0);
    pm(1'b1, 16'h1300, 8'h00); pm(1'b0, 16'h1300, 8'h00);
    chk("prog no key", q, 32'hff);
    rd(ASTA); chk("refuse ev", q, 32'h8);
    wr(ASTA, 32'hf);
    wr(AKEY, 32'ha5); bcnt = 0;
    wr(ACTL, 32'h61); wait_idle();
    chk("lock length", bcnt, LC);
    rd(ASTA); chk("lock ev", q, 32'h4);
    wr(ASTA, 32'hf); wr(ACTL, 32'h50);
    pm(1'b1, 16'h1300, 8'h00); pm(1'b0, 16'h1300, 8'h00);
    chk("prog locked", q, 32'hff);
    bcnt = 0;
    wr(ACTL, 32'ha1); repeat (3) @(posedge clk_i);
    chk("erase locked", bcnt, 0);
    $display("test lock done");
    close_out();
  end
endmodule
